// ### core/nfc_pkg.sv
// Package of constants for the NOR flash host-side controller
package nfc_pkg;
    // Bus widths
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RST_PULSE_NS = 500;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_STANDBY_US = 20;
    localparam int RST_STANDBY_CYC = (RST_STANDBY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_NS = 200;
    localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_NS = 60;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // Command codes
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_QUERY = 16'h0098;
    localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [ADDR_W-1:0] ADDR_QUERY = 23'h000055;
    // Query and OTP fields
    localparam logic [7:0] QUERY_UPPER = 8'h00;
    localparam int CUST_LOCK_BIT = 6;
    localparam int FACT_LOCK_BIT = 7;
    localparam logic [ADDR_W-1:0] OTP_LAST = 23'h0000FF;
    // User operation codes
    localparam logic [2:0] OP_WRITE = 3'h0;
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_RESET_CMD = 3'h2;
    localparam logic [2:0] OP_QUERY = 3'h3;
    localparam logic [2:0] OP_ACC_PROG = 3'h4;
    localparam logic [2:0] OP_HW_RESET = 3'h5;
    typedef enum logic [2:0] {
        NFC_POWERUP = 3'b000,
        NFC_IDLE = 3'b001,
        NFC_WR = 3'b010,
        NFC_WR_GAP = 3'b011,
        NFC_RD = 3'b100,
        NFC_RST_LOW = 3'b101,
        NFC_WAKE = 3'b110
    } nfc_state_t;
endpackage

// ### core/nfc_host.sv
// Host controller that drives the NOR flash pins
`timescale 1ns/100ps
module nfc_host
#(
    parameter int RST_HOLD_CYC = nfc_pkg::RST_STANDBY_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // User request
    input wire logic req_i,
    input wire logic [2:0] op_i,
    input wire logic [nfc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [nfc_pkg::DATA_W-1:0] wdata_i,
    input wire logic protect_i,
    input wire logic accel_i,
    input wire logic otp_mode_i,
    // User answer
    output logic busy_o,
    output logic done_o,
    output logic [nfc_pkg::DATA_W-1:0] rdata_o,
    output logic query_mode_o,
    output logic cust_locked_o,
    output logic fact_locked_o,
    // Flash pins
    output logic chip_select_lower_half_n_o,
    output logic chip_select_upper_half_n_o,
    output logic output_enable_n_o,
    output logic write_strobe_n_o,
    output logic reset_n_o,
    output logic boot_protect_accel_pin_o,
    output logic boot_protect_accel_hv_o,
    output logic [nfc_pkg::ADDR_W-1:0] addr_o,
    output logic [nfc_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic [nfc_pkg::DATA_W-1:0] dq_i
);
    import nfc_pkg::*;
    nfc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
    logic [2:0] op_reg, op_next;
    logic second_reg, second_next;
    logic [ADDR_W-1:0] addr_reg, addr_next, paddr_reg, paddr_next;
    logic [DATA_W-1:0] wd_reg, wd_next, pdata_reg, pdata_next, rdata_reg, rdata_next;
    logic cs_lo_reg, cs_lo_next, cs_hi_reg, cs_hi_next, oe_reg, oe_next, we_reg, we_next;
    logic rst_reg, rst_next, doe_reg, doe_next, busy_reg, busy_next, done_reg, done_next;
    logic query_reg, query_next, cust_reg, cust_next, fact_reg, fact_next;
    logic prot_reg, prot_next, hv_reg, hv_next;
    logic upper_sel;
    assign upper_sel = addr_reg[ADDR_W-1]; // Upper address bit picks the half
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        op_next = op_reg;
        second_next = second_reg;
        addr_next = addr_reg;
        paddr_next = paddr_reg;
        wd_next = wd_reg;
        pdata_next = pdata_reg;
        rdata_next = rdata_reg;
        cs_lo_next = cs_lo_reg;
        cs_hi_next = cs_hi_reg;
        oe_next = oe_reg;
        we_next = we_reg;
        rst_next = rst_reg;
        doe_next = doe_reg;
        busy_next = 1'b1;
        done_next = 1'b0;
        query_next = query_reg;
        cust_next = cust_reg;
        fact_next = fact_reg;
        prot_next = protect_i;
        // Accelerate level refused while OTP region enabled
        hv_next = accel_i && !otp_mode_i;
        unique case (state_reg)
            NFC_POWERUP: begin
                // Reset held low from power-up, longest of both holds
                rst_next = 1'b0;
                doe_next = 1'b0;
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(RST_HOLD_CYC) && cnt_reg >= CNT_W'(RST_PULSE_CYC)) begin
                    rst_next = 1'b1;
                    cnt_next = '0;
                    state_next = NFC_WAKE;
                end
            end
            NFC_RST_LOW: begin
                rst_next = 1'b0;
                doe_next = 1'b0;
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(RST_HOLD_CYC) && cnt_reg >= CNT_W'(RST_PULSE_CYC)) begin
                    rst_next = 1'b1;
                    cnt_next = '0;
                    query_next = 1'b0;
                    state_next = NFC_WAKE;
                end
            end
            NFC_WAKE: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(WAKE_CYC)) begin
                    cnt_next = '0;
                    done_next = 1'b1;
                    state_next = NFC_IDLE;
                end
            end
            NFC_IDLE: begin
                busy_next = 1'b0;
                second_next = 1'b0;
                if (req_i) begin
                    busy_next = 1'b1;
                    op_next = op_i;
                    addr_next = addr_i;
                    wd_next = wdata_i;
                    paddr_next = addr_i;
                    pdata_next = wdata_i;
                    cnt_next = '0;
                    unique case (op_i)
                        OP_READ: state_next = NFC_RD;
                        OP_HW_RESET: begin
                            rst_next = 1'b0;
                            doe_next = 1'b0;
                            state_next = NFC_RST_LOW;
                        end
                        // Reset command address is a don't care
                        OP_RESET_CMD: begin
                            wd_next = CMD_RESET;
                            state_next = NFC_WR;
                        end
                        OP_QUERY: begin
                            addr_next = ADDR_QUERY;
                            wd_next = CMD_QUERY;
                            state_next = NFC_WR;
                        end
                        OP_ACC_PROG: begin
                            wd_next = CMD_PROGRAM;
                            state_next = NFC_WR;
                        end
                        default: state_next = NFC_WR;
                    endcase
                end
            end
            NFC_WR: begin
                // Chip select low, strobe low, output enable high
                cnt_next = cnt_reg + 1'b1;
                oe_next = 1'b1;
                cs_lo_next = upper_sel;
                cs_hi_next = !upper_sel;
                we_next = 1'b0;
                doe_next = 1'b1;
                if (cnt_reg >= CNT_W'(STROBE_CYC)) begin
                    we_next = 1'b1;
                    cnt_next = '0;
                    state_next = NFC_WR_GAP;
                end
            end
            NFC_WR_GAP: begin
                // Strobe released first so data holds past its rising edge
                cs_lo_next = 1'b1;
                cs_hi_next = 1'b1;
                doe_next = 1'b0;
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(STROBE_CYC)) begin
                    cnt_next = '0;
                    if (op_reg == OP_ACC_PROG && !second_reg) begin
                        second_next = 1'b1;
                        addr_next = paddr_reg;
                        wd_next = pdata_reg;
                        state_next = NFC_WR;
                    end else begin
                        if (op_reg == OP_QUERY) begin
                            query_next = 1'b1;
                        end
                        if (op_reg == OP_RESET_CMD) begin
                            query_next = 1'b0;
                        end
                        done_next = 1'b1;
                        state_next = NFC_IDLE;
                    end
                end
            end
            NFC_RD: begin
                cnt_next = cnt_reg + 1'b1;
                cs_lo_next = upper_sel;
                cs_hi_next = !upper_sel;
                we_next = 1'b1;
                oe_next = 1'b0;
                doe_next = 1'b0;
                // Extra cycles cover the two-stage sampling of the data pins
                if (cnt_reg >= CNT_W'(STROBE_CYC + 2)) begin
                    rdata_next = query_reg ? {QUERY_UPPER, dq_s2_reg[7:0]} : dq_s2_reg;
                    if (otp_mode_i && addr_reg <= OTP_LAST) begin
                        cust_next = dq_s2_reg[CUST_LOCK_BIT];
                        fact_next = dq_s2_reg[FACT_LOCK_BIT];
                    end
                    oe_next = 1'b1;
                    cs_lo_next = 1'b1;
                    cs_hi_next = 1'b1;
                    cnt_next = '0;
                    done_next = 1'b1;
                    state_next = NFC_IDLE;
                end
            end
            default: state_next = NFC_POWERUP;
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= NFC_POWERUP;
            cnt_reg <= '0;
            op_reg <= OP_WRITE;
            second_reg <= 1'b0;
            addr_reg <= '0;
            paddr_reg <= '0;
            wd_reg <= '0;
            pdata_reg <= '0;
            rdata_reg <= '0;
            cs_lo_reg <= 1'b1;
            cs_hi_reg <= 1'b1;
            oe_reg <= 1'b1;
            we_reg <= 1'b1;
            rst_reg <= 1'b0;
            doe_reg <= 1'b0;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            query_reg <= 1'b0;
            cust_reg <= 1'b0;
            fact_reg <= 1'b0;
            prot_reg <= 1'b0;
            hv_reg <= 1'b0;
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            op_reg <= op_next;
            second_reg <= second_next;
            addr_reg <= addr_next;
            paddr_reg <= paddr_next;
            wd_reg <= wd_next;
            pdata_reg <= pdata_next;
            rdata_reg <= rdata_next;
            cs_lo_reg <= cs_lo_next;
            cs_hi_reg <= cs_hi_next;
            oe_reg <= oe_next;
            we_reg <= we_next;
            rst_reg <= rst_next;
            doe_reg <= doe_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            query_reg <= query_next;
            cust_reg <= cust_next;
            fact_reg <= fact_next;
            prot_reg <= prot_next;
            hv_reg <= hv_next;
            dq_s1_reg <= dq_i;
            dq_s2_reg <= dq_s1_reg;
        end
    end
    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign rdata_o = rdata_reg;
    assign query_mode_o = query_reg;
    assign cust_locked_o = cust_reg;
    assign fact_locked_o = fact_reg;
    assign chip_select_lower_half_n_o = cs_lo_reg;
    assign chip_select_upper_half_n_o = cs_hi_reg;
    assign output_enable_n_o = oe_reg;
    assign write_strobe_n_o = we_reg;
    assign reset_n_o = rst_reg;
    assign boot_protect_accel_pin_o = prot_reg;
    assign boot_protect_accel_hv_o = hv_reg;
    assign addr_o = addr_reg;
    assign dq_o = wd_reg;
    assign dq_oe_o = doe_reg;
endmodule // nfc_host

// ### tb/nfc_host_chk.sv
// Port assertions for the flash host controller
`timescale 1ns/100ps
module nfc_host_chk
    import nfc_pkg::*;
#(
    parameter int RST_HOLD_CYC = RST_STANDBY_CYC
) (
    // Clock, reset and user side
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic [2:0] op_i,
    input wire logic protect_i,
    input wire logic otp_mode_i,
    input wire logic busy_o,
    input wire logic query_mode_o,
    // Flash pins
    input wire logic chip_select_lower_half_n_o,
    input wire logic chip_select_upper_half_n_o,
    input wire logic output_enable_n_o,
    input wire logic write_strobe_n_o,
    input wire logic reset_n_o,
    input wire logic boot_protect_accel_pin_o,
    input wire logic boot_protect_accel_hv_o,
    input wire logic dq_oe_o
);
    logic [15:0] lo_cnt_reg, lo_cnt_next;
    logic [7:0] hi_cnt_reg, hi_cnt_next;
    logic sel;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    assign sel = !(chip_select_lower_half_n_o && chip_select_upper_half_n_o);
    // Saturate so a long idle spell cannot wrap back under the wake count
    always_comb begin
        lo_cnt_next = reset_n_o ? 16'h0000 : lo_cnt_reg + 16'h0001;
        hi_cnt_next = !reset_n_o ? 8'h00 : (hi_cnt_reg == 8'hFF ? hi_cnt_reg : hi_cnt_reg + 8'h01);
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lo_cnt_reg <= 16'h0000;
            hi_cnt_reg <= 8'h00;
        end else begin
            lo_cnt_reg <= lo_cnt_next;
            hi_cnt_reg <= hi_cnt_next;
        end
    end
    sequence s_take(logic [2:0] code);
        req_i && !busy_o && op_i == code;
    endsequence
    property p_wr_qual;
        !write_strobe_n_o |-> output_enable_n_o && sel;
    endproperty
    a_wr_qual: assert property (p_wr_qual) else $error("write strobe without select or with read enable");
    property p_float;
        !reset_n_o |-> !dq_oe_o && write_strobe_n_o;
    endproperty
    a_float: assert property (p_float) else $error("data driven during flash reset");
    property p_rst_len;
        $rose(reset_n_o) |-> lo_cnt_reg >= RST_PULSE_CYC;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("flash reset pulse too short");
    property p_wake;
        sel |-> hi_cnt_reg >= WAKE_CYC;
    endproperty
    a_wake: assert property (p_wake) else $error("access inside wake interval");
    property p_busy_rst;
        !reset_n_o |-> busy_o;
    endproperty
    a_busy_rst: assert property (p_busy_rst) else $error("idle while flash reset held");
    property p_hv_otp;
        otp_mode_i [*2] |-> !boot_protect_accel_hv_o;
    endproperty
    a_hv_otp: assert property (p_hv_otp) else $error("accelerate level in region mode");
    property p_pin;
        (protect_i != boot_protect_accel_pin_o) |=> boot_protect_accel_pin_o == $past(protect_i);
    endproperty
    a_pin: assert property (p_pin) else $error("protect pin does not follow request");
    property p_query_on;
        s_take(OP_QUERY) |-> ##[1:60] query_mode_o;
    endproperty
    a_query_on: assert property (p_query_on) else $error("query flag not set");
    property p_query_off;
        s_take(OP_RESET_CMD) |-> ##[1:60] !query_mode_o;
    endproperty
    a_query_off: assert property (p_query_off) else $error("query flag kept after reset command");
    property p_query_hw;
        s_take(OP_HW_RESET) |-> ##[1:400] !query_mode_o;
    endproperty
    a_query_hw: assert property (p_query_hw) else $error("query flag kept after flash reset");
endmodule // nfc_host_chk

// ### tb/nfc_flash_mdl.sv
// Behavioural flash device at the host's far side
`timescale 1ns/100ps
module nfc_flash_mdl
    import nfc_pkg::*;
(
    // Control pins from host
    input wire logic chip_select_lower_half_n_i,
    input wire logic chip_select_upper_half_n_i,
    input wire logic output_enable_n_i,
    input wire logic write_strobe_n_i,
    input wire logic reset_n_i,
    input wire logic boot_protect_accel_pin_i,
    input wire logic boot_protect_accel_hv_i,
    // Address and data wire
    input wire logic [nfc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [nfc_pkg::DATA_W-1:0] dq_i,
    output logic [nfc_pkg::DATA_W-1:0] dq_o
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] rv;
    logic [DATA_W-1:0] gone = 16'h5A5A;
    logic query = 1'b0;
    logic prog_pend = 1'b0;
    // Outputs stay invalid until the wake-up time after reset release
    logic awake = 1'b0;
    // Bumped on every array write so the read value is recomputed
    logic wr_tick = 1'b0;
    logic sel, rd_en, boot;
    assign sel = !(chip_select_lower_half_n_i && chip_select_upper_half_n_i);
    assign rd_en = sel && !output_enable_n_i && reset_n_i && awake;
    assign boot = addr_i < 23'h002000 || addr_i >= 23'h7FE000;
    always @(reset_n_i) begin
        awake = 1'b0;
        if (reset_n_i) begin
            awake <= #(WAKE_NS) 1'b1;
        end
    end
    always @(addr_i, query, wr_tick) begin
        if (query) begin
            rv = {QUERY_UPPER, addr_i[7:0] ^ 8'h51};
        end else begin
            rv = mem.exists(addr_i) ? mem[addr_i] : addr_i[15:0] ^ 16'hA5C3;
        end
    end
    // Released bus flips, so stale data cannot pass for a read
    always @(negedge rd_en) gone = ~rv;
    assign dq_o = rd_en ? rv : gone;
    always @(negedge reset_n_i) begin
        query = 1'b0;
        prog_pend = 1'b0;
    end
    always @(posedge write_strobe_n_i) begin
        if (reset_n_i && sel && output_enable_n_i) begin
            if (dq_i == CMD_RESET) begin
                query = 1'b0;
                prog_pend = 1'b0;
            end else if (dq_i == CMD_QUERY && addr_i == ADDR_QUERY) begin
                query = 1'b1;
            end else if (dq_i == CMD_PROGRAM && !prog_pend) begin
                prog_pend = 1'b1;
            end else begin
                prog_pend = 1'b0;
                if (!boot || boot_protect_accel_pin_i || boot_protect_accel_hv_i) begin
                    mem[addr_i] = dq_i;
                    wr_tick = ~wr_tick;
                end
            end
        end
    end
endmodule // nfc_flash_mdl

// ### tb/tb_nfc_host.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
module tb_nfc_host;
    import nfc_pkg::*;
    logic core_clk_i = 0, rst_b_i = 0, req_i = 0, protect_i = 1, accel_i = 0, otp_mode_i = 0;
    logic [2:0] op_i = 0;
    logic [ADDR_W-1:0] addr_i = 0, addr_o, a0, a;
    logic [DATA_W-1:0] wdata_i = 0, rdata_o, dq_o, mdl_dq, dq_w, d0, d;
    logic busy_o, done_o, query_mode_o, cust_locked_o, fact_locked_o, cs_l, cs_u, oe_n, we_n, rst_n, pin, hv, dq_oe;
    int error_cnt = 0, n_checks = 0;
    assign dq_w = dq_oe ? dq_o : mdl_dq;
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    nfc_host #(.RST_HOLD_CYC(130)) dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .op_i(op_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .protect_i(protect_i), .accel_i(accel_i), .otp_mode_i(otp_mode_i),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .query_mode_o(query_mode_o),
        .cust_locked_o(cust_locked_o), .fact_locked_o(fact_locked_o), .chip_select_lower_half_n_o(cs_l),
        .chip_select_upper_half_n_o(cs_u), .output_enable_n_o(oe_n), .write_strobe_n_o(we_n), .reset_n_o(rst_n),
        .boot_protect_accel_pin_o(pin), .boot_protect_accel_hv_o(hv), .addr_o(addr_o), .dq_o(dq_o),
        .dq_oe_o(dq_oe), .dq_i(dq_w));
    nfc_flash_mdl mdl_u (.chip_select_lower_half_n_i(cs_l), .chip_select_upper_half_n_i(cs_u),
        .output_enable_n_i(oe_n), .write_strobe_n_i(we_n), .reset_n_i(rst_n), .boot_protect_accel_pin_i(pin),
        .boot_protect_accel_hv_i(hv), .addr_i(addr_o), .dq_i(dq_w), .dq_o(mdl_dq));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Partner's contents of a never-written word, and its query answer
    function automatic logic [15:0] blank_word(input logic [ADDR_W-1:0] ad);
        return ad[15:0] ^ 16'hA5C3;
    endfunction
    function automatic logic [15:0] query_word(input logic [ADDR_W-1:0] ad);
        return {QUERY_UPPER, ad[7:0] ^ 8'h51};
    endfunction
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Bounded wait for idle or for the done pulse
    task automatic wait_for(input bit idle);
        for (int i = 0; i < 20000; i++) begin
            if (idle ? busy_o === 1'b0 : done_o === 1'b1) return;
            @(negedge core_clk_i);
        end
        error_cnt++;
        conclude();
    endtask
    task automatic run(input logic [2:0] o, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
        wait_for(1);
        req_i = 1;
        op_i = o;
        addr_i = ad;
        wdata_i = wd;
        @(negedge core_clk_i);
        req_i = 0;
        wait_for(0);
        @(negedge core_clk_i);
    endtask
    initial begin
        void'($urandom(86750));
        repeat (8) @(negedge core_clk_i);
        chk("flash_reset", rst_n, 0);
        chk("dq_drive", dq_oe, 0);
        rst_b_i = 1;
        wait_for(0);
        @(negedge core_clk_i);
        // Data words keep bit 15 set so none reads as a command
        for (int i = 0; i < 6; i++) begin
            a = {1'($urandom), 2'b01, 20'($urandom)};
            d = {1'b1, 15'($urandom)};
            run(OP_WRITE, a, d);
            run(OP_READ, a, 0);
            chk("array_word", rdata_o, d);
        end
        a0 = a;
        d0 = d;
        for (int p = 0; p < 2; p++) begin
            protect_i = p[0];
            a = p ? 23'h7FFFF0 : 23'h000010;
            run(OP_WRITE, a, d);
            run(OP_READ, a, 0);
            chk("boot_word", rdata_o, p ? d : blank_word(a));
        end
        protect_i = 0;
        accel_i = 1;
        run(OP_ACC_PROG, 23'h000020, d0);
        run(OP_READ, 23'h000020, 0);
        chk("accel_word", rdata_o, d0);
        otp_mode_i = 1;
        repeat (2) @(negedge core_clk_i);
        chk("accel_level", hv, 0);
        a = {15'h0, 7'($urandom), 1'b1};
        run(OP_READ, a, 0);
        d = blank_word(a);
        chk("cust_lock", cust_locked_o, d[6]);
        chk("fact_lock", fact_locked_o, d[7]);
        otp_mode_i = 0;
        accel_i = 0;
        protect_i = 1;
        run(OP_QUERY, 0, 0);
        chk("query_flag", query_mode_o, 1);
        run(OP_READ, a, 0);
        chk("query_word", rdata_o, query_word(a));
        run(OP_RESET_CMD, a, 0);
        chk("query_flag", query_mode_o, 0);
        run(OP_READ, a0, 0);
        chk("array_word", rdata_o, d0);
        run(OP_QUERY, 0, 0);
        run(OP_HW_RESET, 0, 0);
        chk("query_flag", query_mode_o, 0);
        run(OP_READ, a0, 0);
        chk("array_word", rdata_o, d0);
        conclude();
    end
endmodule // tb_nfc_host
bind nfc_host nfc_host_chk #(.RST_HOLD_CYC(RST_HOLD_CYC)) chk_u (.core_clk_i, .rst_b_i, .req_i, .op_i, .protect_i,
    .otp_mode_i, .busy_o, .query_mode_o, .chip_select_lower_half_n_o, .chip_select_upper_half_n_o,
    .output_enable_n_o, .write_strobe_n_o, .reset_n_o, .boot_protect_accel_pin_o, .boot_protect_accel_hv_o, .dq_oe_o);
